// ---- tieo_ctrl.sv ----
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - capture input one edge field: 00 none, 01 rise, 10 fall, 11 both
// - capture input zero edge field in bits 1:0, same encoding
// - capture edges act only in free-running and pulse width modes
// - event count edge field at bits 3:2 selects none, rise, fall, both
// - trigger edge field at bits 1:0 selects none, rise, fall, both on pin zero
// - event edges honoured only with event enable set or event count mode
// - trigger edges honoured only in trigger pulse or one-shot mode
// - option bit 5 makes register one capture, free-running mode only
// - option bit 4 makes register zero capture, free-running mode only
// - overflow flag sets on wrap to zero in free-running or pulse width mode
// - overflow interrupt fires with the flag, never in other modes
// - overflow flag clears on software write of zero or while disabled
// - reading the flag or option register leaves the flag unchanged
// - writing one to the overflow flag has no effect
// - register zero: selectable in free-running, capture in pulse width, else compare
// - register zero is read and written live, as 16 bits, resets to zero
// - byte registers accessible by byte, reset to zero
// - clearing enable resets counter, event strobes and overflow flag
// - with event enable the counter advances on event edges
module tieo_ctrl (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic INPUT_PIN_ZERO,
    input wire logic INPUT_PIN_ONE,
    input wire logic COUNT_TICK,
    output logic [15:0] COUNT_VALUE,
    output logic [15:0] CAPTURE_ZERO_VALUE,
    output tieo_pkg::tieo_evt_s TIMER_EVENTS
);
    import tieo_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] sync;
        logic [1:0] prev;
        logic tmr_en;
        logic ext_evt_en;
        logic [2:0] mode;
        logic [3:0] cap_edge;
        logic [3:0] evt_edge;
        logic ccs1;
        logic ccs0;
        logic ovf;
        logic [15:0] ccr0;
        logic [15:0] count;
        logic [31:0] prdata;
        logic err;
        tieo_evt_s evt;
    } tieo_state_s;

    tieo_state_s r;
    tieo_state_s next_r;

    // bits 1:0 = falling, rising enable; both set gives both edges
    function automatic logic edge_hit(input logic [1:0] sel, input logic prv,
                                      input logic cur);
        edge_hit = (sel[0] & cur & ~prv) | (sel[1] & ~cur & prv);
    endfunction

    function automatic logic idx_is(input logic [31:0] adr, input logic [31:0] ofs);
        idx_is = (adr[IDX_W+1:2] == ofs[IDX_W-1:0]);
    endfunction

    // ------------------------------------------------------------
    // mode decode and edge events
    // ------------------------------------------------------------
    logic is_fr;
    logic is_pw;
    logic is_evt;
    logic cap_ok;
    logic evt_ok;
    logic cap0_hit;
    logic cap1_hit;
    logic evt_hit;
    logic trig_hit;
    logic ccr0_cap_sel;
    logic ccr1_cap_sel;
    logic tick;
    logic ovf_set;

    assign is_fr = (r.mode == MODE_FREE_RUN);
    assign is_pw = (r.mode == MODE_PULSE_WIDTH);
    assign is_evt = (r.mode == MODE_EVENT_COUNT);
    assign cap_ok = r.tmr_en & (is_fr | is_pw);
    assign evt_ok = r.tmr_en & (r.ext_evt_en | is_evt);
    // edges use the second and third stages only
    assign cap0_hit = cap_ok & edge_hit(r.cap_edge[CAP0_EDGE_LSB +: 2],
                                        r.prev[0], r.sync[0]);
    assign cap1_hit = cap_ok & edge_hit(r.cap_edge[CAP1_EDGE_LSB +: 2],
                                        r.prev[1], r.sync[1]);
    assign evt_hit = evt_ok & edge_hit(r.evt_edge[EVENT_EDGE_LSB +: 2],
                                       r.prev[0], r.sync[0]);
    assign trig_hit = r.tmr_en
        & (r.mode == MODE_TRIGGER_PULSE | r.mode == MODE_ONE_SHOT)
        & edge_hit(r.evt_edge[TRIGGER_EDGE_LSB +: 2], r.prev[0], r.sync[0]);
    assign ccr0_cap_sel = is_pw | (is_fr & r.ccs0);
    assign ccr1_cap_sel = is_pw | (is_fr & r.ccs1);
    // event edges replace the internal count clock
    assign tick = (r.ext_evt_en | is_evt) ? evt_hit : (r.tmr_en & COUNT_TICK);
    assign ovf_set = tick & (r.count == COUNT_MAX) & (is_fr | is_pw);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup;
    logic wr;
    logic hit_ctl;
    logic hit_cap;
    logic hit_et;
    logic hit_opt;
    logic hit_ccr;
    logic hit_cnt;

    assign setup = PSEL & ~PENABLE;
    assign wr = PSEL & PENABLE & PWRITE;
    assign hit_ctl = idx_is(PADDR, OFS_TIMER_CONTROL_ONE);
    assign hit_cap = idx_is(PADDR, OFS_CAPTURE_EDGE_SELECT);
    assign hit_et = idx_is(PADDR, OFS_EVENT_TRIGGER_EDGE_SELECT);
    assign hit_opt = idx_is(PADDR, OFS_CAPTURE_OPTION_OVERFLOW);
    assign hit_ccr = idx_is(PADDR, OFS_CAPTURE_COMPARE_ZERO);
    assign hit_cnt = idx_is(PADDR, OFS_COUNT_READ);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.meta = {INPUT_PIN_ONE, INPUT_PIN_ZERO};
        next_r.sync = r.meta;
        next_r.prev = r.sync;

        // read data latched in setup; reads have no side effect
        if (setup)
        begin
            next_r.err = ~(hit_ctl | hit_cap | hit_et | hit_opt | hit_ccr | hit_cnt);
            next_r.prdata = 32'h0000_0000;
            if (hit_ctl)
            begin
                next_r.prdata[CTL_TIMER_ENABLE_BIT] = r.tmr_en;
                next_r.prdata[CTL_EXTERNAL_EVENT_ENABLE_BIT] = r.ext_evt_en;
                next_r.prdata[CTL_MODE_LSB +: 3] = r.mode;
            end
            else if (hit_cap)
            begin
                next_r.prdata[3:0] = r.cap_edge;
            end
            else if (hit_et)
            begin
                next_r.prdata[3:0] = r.evt_edge;
            end
            else if (hit_opt)
            begin
                // unused option bits always read zero
                next_r.prdata[CCR1_CAPTURE_SELECT_BIT] = r.ccs1;
                next_r.prdata[CCR0_CAPTURE_SELECT_BIT] = r.ccs0;
                next_r.prdata[OVERFLOW_FLAG_BIT] = r.ovf;
            end
            else if (hit_ccr)
            begin
                next_r.prdata[15:0] = r.ccr0;
            end
            else if (hit_cnt)
            begin
                next_r.prdata[15:0] = r.count;
            end
        end

        // byte registers take lane 0
        if (wr && PSTRB[0])
        begin
            if (hit_ctl)
            begin
                next_r.tmr_en = PWDATA[CTL_TIMER_ENABLE_BIT];
                next_r.ext_evt_en = PWDATA[CTL_EXTERNAL_EVENT_ENABLE_BIT];
                next_r.mode = PWDATA[CTL_MODE_LSB +: 3];
            end
            if (hit_cap)
            begin
                next_r.cap_edge = PWDATA[3:0];
            end
            if (hit_et)
            begin
                next_r.evt_edge = PWDATA[3:0];
            end
            if (hit_opt)
            begin
                next_r.ccs1 = PWDATA[CCR1_CAPTURE_SELECT_BIT];
                next_r.ccs0 = PWDATA[CCR0_CAPTURE_SELECT_BIT];
                // a one leaves the flag as it is
                next_r.ovf = r.ovf & PWDATA[OVERFLOW_FLAG_BIT];
            end
        end

        // only a full halfword write lands
        if (wr && hit_ccr && PSTRB[1:0] == 2'h3)
        begin
            next_r.ccr0 = PWDATA[15:0];
        end
        // capture beats a simultaneous software write
        if (cap0_hit && ccr0_cap_sel)
        begin
            next_r.ccr0 = r.count;
        end

        // counter
        if (!r.tmr_en)
        begin
            next_r.count = COUNT_ZERO;
        end
        else if (is_pw && ((cap0_hit && ccr0_cap_sel) || (cap1_hit && ccr1_cap_sel)))
        begin
            next_r.count = COUNT_ZERO;
        end
        else if (tick)
        begin
            next_r.count = r.count + 16'h0001;
        end

        // hardware set wins over a software clear
        if (ovf_set)
        begin
            next_r.ovf = 1'b1;
        end
        if (!r.tmr_en)
        begin
            next_r.ovf = 1'b0;
        end

        next_r.evt.overflow_irq = ovf_set;
        next_r.evt.capture1_strobe = cap1_hit & ccr1_cap_sel;
        next_r.evt.trigger_strobe = trig_hit;
        next_r.evt.ccr0_capture_mode = ccr0_cap_sel;
        next_r.evt.ccr1_capture_mode = ccr1_cap_sel;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    // zero wait states: the answer stands in the access phase
    assign PREADY = 1'b1;
    assign PRDATA = r.prdata;
    assign PSLVERR = r.err & PSEL & PENABLE;
    assign COUNT_VALUE = r.count;
    assign CAPTURE_ZERO_VALUE = r.ccr0;
    assign TIMER_EVENTS = r.evt;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    property p_irq_with_flag;
        TIMER_EVENTS.overflow_irq |-> r.ovf && $past(is_fr || is_pw);
    endproperty
    a_irq_with_flag: assert property (p_irq_with_flag) else $error("irq without flag");

    property p_ovf_set;
        ovf_set && r.tmr_en |=> r.ovf && TIMER_EVENTS.overflow_irq && r.count == COUNT_ZERO;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

    property p_ovf_disabled;
        !r.tmr_en |=> !r.ovf && r.count == COUNT_ZERO && !TIMER_EVENTS.overflow_irq;
    endproperty
    a_ovf_disabled: assert property (p_ovf_disabled) else $error("disable did not clear");

    property p_write_one;
        wr && hit_opt && PSTRB[0] && PWDATA[0] && !r.ovf && !ovf_set |=> !r.ovf;
    endproperty
    a_write_one: assert property (p_write_one) else $error("software set the flag");

    property p_read_keeps;
        PSEL && !PWRITE && hit_opt && r.ovf && r.tmr_en |=> r.ovf;
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read cleared the flag");

    property p_no_capture;
        !(is_fr || is_pw) && !(wr && hit_ccr)
            |=> !TIMER_EVENTS.capture1_strobe && r.ccr0 == $past(r.ccr0);
    endproperty
    a_no_capture: assert property (p_no_capture) else $error("capture in wrong mode");

    property p_capture_value;
        cap0_hit && ccr0_cap_sel |=> r.ccr0 == $past(r.count);
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("capture value wrong");

    property p_event_gate;
        r.tmr_en && !r.ext_evt_en && !is_evt && !is_pw && !COUNT_TICK
            |=> r.count == $past(r.count);
    endproperty
    a_event_gate: assert property (p_event_gate) else $error("event edge not gated");

    property p_trigger;
        trig_hit |=> TIMER_EVENTS.trigger_strobe
            ##1 (!TIMER_EVENTS.trigger_strobe || $past(trig_hit));
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger strobe wrong");

    property p_rise_capture;
        r.tmr_en && is_fr && r.ccs0 && r.cap_edge[1:0] == EDGE_RISE && !r.prev[0] && r.sync[0]
            |=> r.ccr0 == $past(r.count);
    endproperty
    a_rise_capture: assert property (p_rise_capture) else $error("rising edge missed");

    property p_select_one;
        1'b1 |=> TIMER_EVENTS.ccr1_capture_mode == $past(is_pw || (is_fr && r.ccs1));
    endproperty
    a_select_one: assert property (p_select_one) else $error("register one select wrong");

    property p_pw_mode;
        is_pw |=> TIMER_EVENTS.ccr0_capture_mode && TIMER_EVENTS.ccr1_capture_mode;
    endproperty
    a_pw_mode: assert property (p_pw_mode) else $error("pw not capture");

    property p_select_zero;
        !is_fr && !is_pw |=> !TIMER_EVENTS.ccr0_capture_mode;
    endproperty
    a_select_zero: assert property (p_select_zero) else $error("not compare");

    property p_pw_clear;
        is_pw && (cap0_hit || cap1_hit) |=> r.count == COUNT_ZERO;
    endproperty
    a_pw_clear: assert property (p_pw_clear) else $error("pw count kept");

    property p_trig_gate;
        !(r.mode == MODE_TRIGGER_PULSE || r.mode == MODE_ONE_SHOT)
            |=> !TIMER_EVENTS.trigger_strobe;
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger in wrong mode");

    property p_irq_modes;
        !(is_fr || is_pw) |=> !TIMER_EVENTS.overflow_irq;
    endproperty
    a_irq_modes: assert property (p_irq_modes) else $error("irq in wrong mode");

    property p_event_count;
        evt_hit && !is_pw |=> r.count == $past(r.count) + 16'h0001;
    endproperty
    a_event_count: assert property (p_event_count) else $error("event not counted");

    property p_write_zero;
        wr && hit_opt && PSTRB[0] && !PWDATA[OVERFLOW_FLAG_BIT] && !ovf_set |=> !r.ovf;
    endproperty
    a_write_zero: assert property (p_write_zero) else $error("flag not cleared");

endmodule
`default_nettype wire

// ---- tieo_pkg.sv ----
`default_nettype none
package tieo_pkg;

    // ------------------------------------------------------------
    // register offsets (printed, not word aligned: kept as indices)
    // ------------------------------------------------------------
    localparam logic [31:0] OFS_CAPTURE_EDGE_SELECT = 32'hfffff593;
    localparam logic [31:0] OFS_EVENT_TRIGGER_EDGE_SELECT = 32'hfffff594;
    localparam logic [31:0] OFS_CAPTURE_OPTION_OVERFLOW = 32'h0ffff595;
    localparam logic [31:0] OFS_TIMER_CONTROL_ONE = 32'h0ffff591;
    localparam logic [31:0] OFS_CAPTURE_COMPARE_ZERO = 32'h0ffff596;
    localparam logic [31:0] OFS_COUNT_READ = 32'h0ffff597;
    // decoded from PADDR[13:2]: byte address is four times the index
    localparam int IDX_W = 12;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_TIMER_ENABLE_BIT = 7;
    localparam int CTL_EXTERNAL_EVENT_ENABLE_BIT = 5;
    localparam int CTL_MODE_LSB = 0;
    localparam int CAP1_EDGE_LSB = 2;
    localparam int CAP0_EDGE_LSB = 0;
    localparam int EVENT_EDGE_LSB = 2;
    localparam int TRIGGER_EDGE_LSB = 0;
    localparam int CCR1_CAPTURE_SELECT_BIT = 5;
    localparam int CCR0_CAPTURE_SELECT_BIT = 4;
    localparam int OVERFLOW_FLAG_BIT = 0;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] BYTE_REG_RESET = 8'h00;
    localparam logic [15:0] CCR0_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // timer modes and edge codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_INTERVAL = 3'h0;
    localparam logic [2:0] MODE_EVENT_COUNT = 3'h1;
    localparam logic [2:0] MODE_TRIGGER_PULSE = 3'h2;
    localparam logic [2:0] MODE_ONE_SHOT = 3'h3;
    localparam logic [2:0] MODE_PWM = 3'h4;
    localparam logic [2:0] MODE_FREE_RUN = 3'h5;
    localparam logic [2:0] MODE_PULSE_WIDTH = 3'h6;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    typedef struct packed {
        logic overflow_irq;
        logic capture1_strobe;
        logic trigger_strobe;
        logic ccr0_capture_mode;
        logic ccr1_capture_mode;
    } tieo_evt_s;

endpackage
`default_nettype wire

// ---- tieo_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module tieo_pins (
    input wire logic CLK,
    output logic PIN_ZERO,
    output logic PIN_ONE
);
    initial
    begin
        PIN_ZERO = 1'b0;
        PIN_ONE = 1'b0;
    end
    // levels move just after an edge and stand for hold cycles;
    // short holds model a prompt source, long holds a slow one
    task automatic drive(input logic v0, input logic v1, input int hold);
        @(posedge CLK);
        PIN_ZERO <= v0;
        PIN_ONE <= v1;
        repeat (hold) @(posedge CLK);
    endtask
endmodule
`default_nettype wire

// ---- timer_input_edge_option_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer_input_edge_option_ctrl_test;
    import tieo_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, tick, pin0, pin1, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [15:0] cnt_v, ccr0_v;
    tieo_evt_s ev;
    int error_cnt, n_checks, n_c1, n_tr, n_ov;
    tieo_ctrl dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .INPUT_PIN_ZERO(pin0), .INPUT_PIN_ONE(pin1), .COUNT_TICK(tick),
        .COUNT_VALUE(cnt_v), .CAPTURE_ZERO_VALUE(ccr0_v), .TIMER_EVENTS(ev));
    tieo_pins pins (.CLK(clk), .PIN_ZERO(pin0), .PIN_ONE(pin1));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (ev.capture1_strobe === 1'b1) n_c1++;
        if (ev.trigger_strobe === 1'b1) n_tr++;
        if (ev.overflow_irq === 1'b1) n_ov++;
    end
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    task automatic apb(input logic w, input logic [31:0] idx, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx[29:0], 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            error_cnt++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
    endtask
    // fields are only rewritten with the timer stopped
    task automatic try(input logic [7:0] ctl, input logic [7:0] cap, input logic [7:0] evt,
        input logic [7:0] opt);
        wr(OFS_TIMER_CONTROL_ONE, 8'h00);
        wr(OFS_CAPTURE_EDGE_SELECT, cap);
        wr(OFS_EVENT_TRIGGER_EDGE_SELECT, evt);
        wr(OFS_CAPTURE_OPTION_OVERFLOW, opt);
        wr(OFS_TIMER_CONTROL_ONE, ctl | 8'h80);
        n_c1 = 0;
        n_tr = 0;
        pins.drive(1'b1, 1'b1, 8);
        pins.drive(1'b0, 1'b0, 8);
    endtask
    function automatic logic [31:0] nedge(input logic [1:0] c);
        return {31'h0, c[0]} + {31'h0, c[1]};
    endfunction
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] regs [5];
        regs = '{OFS_CAPTURE_EDGE_SELECT, OFS_EVENT_TRIGGER_EDGE_SELECT,
            OFS_CAPTURE_OPTION_OVERFLOW, OFS_CAPTURE_COMPARE_ZERO, OFS_COUNT_READ};
        {psel, penable, pwrite, tick, rst_n} = '0;
        {paddr, pwdata} = '0;
        pstrb = 4'hf;
        error_cnt = 0;
        n_checks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[i])
        begin
            apb(1'b0, regs[i], 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 32'h0ffff598, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, OFS_CAPTURE_COMPARE_ZERO, 32'h1234);
        for (int c = 0; c < 4; c++)
        begin
            try(8'h05, 8'(c << 2), 8'h00, 8'h20);
            chk(n_c1, nedge(2'(c)));
            try(8'h01, 8'h00, 8'(c << 2), 8'h00);
            chk({16'h0, cnt_v}, nedge(2'(c)));
            try(8'h02, 8'h00, 8'(c), 8'h00);
            chk(n_tr, nedge(2'(c)));
            try(8'h03, 8'h00, 8'(c), 8'h00);
            chk(n_tr, nedge(2'(c)));
        end
        try(8'h00, 8'h0f, 8'h0f, 8'h30);
        chk(n_c1, 32'h0);
        chk(n_tr, 32'h0);
        chk({16'h0, cnt_v}, 32'h0);
        chk({16'h0, ccr0_v}, 32'h1234);
        chk({30'h0, ev.ccr0_capture_mode, ev.ccr1_capture_mode}, 32'h0);
        try(8'h20, 8'h00, 8'h0c, 8'h00);
        chk({16'h0, cnt_v}, 32'h2);
        try(8'h05, 8'h01, 8'h00, 8'h30);
        chk({30'h0, ev.ccr0_capture_mode, ev.ccr1_capture_mode}, 32'h3);
        try(8'h05, 8'h01, 8'h00, 8'h10);
        apb(1'b1, OFS_CAPTURE_COMPARE_ZERO, 32'h5a5a);
        apb(1'b0, OFS_CAPTURE_COMPARE_ZERO, 32'h0);
        chk(rd, 32'h5a5a);
        pstrb <= 4'h1;
        apb(1'b1, OFS_CAPTURE_COMPARE_ZERO, 32'hbeef);
        pstrb <= 4'hf;
        apb(1'b0, OFS_CAPTURE_COMPARE_ZERO, 32'h0);
        chk(rd, 32'h5a5a);
        @(posedge clk);
        tick <= 1'b1;
        repeat (20) @(posedge clk);
        tick <= 1'b0;
        pins.drive(1'b1, 1'b0, 8);
        pins.drive(1'b0, 1'b0, 8);
        chk({16'h0, ccr0_v}, 32'h14);
        n_ov = 0;
        @(posedge clk);
        tick <= 1'b1;
        repeat (65516) @(posedge clk);
        tick <= 1'b0;
        repeat (3) @(posedge clk);
        chk(n_ov, 32'h1);
        chk({16'h0, cnt_v}, 32'h0);
        apb(1'b0, OFS_CAPTURE_OPTION_OVERFLOW, 32'h0);
        apb(1'b0, OFS_CAPTURE_OPTION_OVERFLOW, 32'h0);
        chk(rd, 32'h11);
        wr(OFS_CAPTURE_OPTION_OVERFLOW, 8'h11);
        apb(1'b0, OFS_CAPTURE_OPTION_OVERFLOW, 32'h0);
        chk(n_ov, 32'h1);
        chk(rd, 32'h11);
        wr(OFS_CAPTURE_OPTION_OVERFLOW, 8'h10);
        apb(1'b0, OFS_CAPTURE_OPTION_OVERFLOW, 32'h0);
        chk(rd, 32'h10);
        wr(OFS_CAPTURE_OPTION_OVERFLOW, 8'h11);
        apb(1'b0, OFS_CAPTURE_OPTION_OVERFLOW, 32'h0);
        chk(rd, 32'h10);
        // pulse width: pin one rising captures and clears the counter
        try(8'h06, 8'h04, 8'h00, 8'h00);
        chk(n_c1, 32'h1);
        @(posedge clk);
        tick <= 1'b1;
        repeat (10) @(posedge clk);
        tick <= 1'b0;
        @(posedge clk);
        chk({16'h0, cnt_v}, 32'ha);
        pins.drive(1'b1, 1'b1, 8);
        chk(n_c1, 32'h2);
        chk({16'h0, cnt_v}, 32'h0);
        chk({16'h0, ccr0_v}, 32'h14);
        chk({30'h0, ev.ccr0_capture_mode, ev.ccr1_capture_mode}, 32'h3);
        @(posedge clk);
        tick <= 1'b1;
        repeat (5) @(posedge clk);
        tick <= 1'b0;
        wr(OFS_TIMER_CONTROL_ONE, 8'h05);
        wr(OFS_TIMER_CONTROL_ONE, 8'h00);
        apb(1'b0, OFS_COUNT_READ, 32'h0);
        chk(rd, 32'h0);
        chk({16'h0, cnt_v}, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
